// [hdl/pcl_loader.sv]
`timescale 1ns/100ps
module pcl_loader #(
  parameter int PORTS = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  // memory word port
  output logic memReq,
  output logic [7:0] memAddr,
  input wire logic memValid,
  input wire logic [15:0] memData,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // configuration fields
  output logic cfgReady,
  output logic [PORTS-1:0][31:0] cfgOff68,
  output logic [PORTS-1:0][31:0] cfgOff74,
  output logic [PORTS-1:0][31:0] cfgOff78,
  output logic [PORTS-1:0][31:0] cfgOff7C,
  output logic [PORTS-1:0][31:0] cfgOff84,
  output logic [PORTS-1:0][31:0] cfgOff88,
  output logic [PORTS-1:0][31:0] cfgOff8C,
  output logic [PORTS-1:0][31:0] cfgOff90,
  output logic [PORTS-1:0][31:0] cfgOff98
);

  pcl_pkg::pcl_state_t state;
  logic autoLoad;
  logic busy;
  logic [3:0] wordsLoaded;
  logic applyValid;
  logic [7:0] applyAddr;
  logic [15:0] applyData;
  logic reloadHit;

  assign reloadHit = regWrite && (regAddr == pcl_pkg::REG_CONTROL) && regWrData[pcl_pkg::CTL_RELOAD_BIT];

  // ----------------------------------------------------------------
  // fetch sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= pcl_pkg::PCL_IDLE;
      memReq <= 1'b0;
      memAddr <= pcl_pkg::WORD_FIRST;
      wordsLoaded <= 4'h0;
      cfgReady <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      case (state)
        pcl_pkg::PCL_IDLE: begin
          // autoload holds at reset, so a fresh part always fetches
          if (autoLoad || reloadHit) begin
            state <= pcl_pkg::PCL_ADDR;
            memAddr <= pcl_pkg::WORD_FIRST;
            wordsLoaded <= 4'h0;
            busy <= 1'b1;
          end
        end
        pcl_pkg::PCL_ADDR: begin
          memReq <= 1'b1;
          state <= pcl_pkg::PCL_WAIT;
        end
        pcl_pkg::PCL_WAIT: begin
          if (memValid) begin
            memReq <= 1'b0;
            wordsLoaded <= wordsLoaded + 4'h1;
            if (memAddr == pcl_pkg::WORD_LAST) begin
              state <= pcl_pkg::PCL_DONE;
            end else begin
              memAddr <= memAddr + pcl_pkg::WORD_STEP;
              state <= pcl_pkg::PCL_ADDR;
            end
          end
        end
        pcl_pkg::PCL_DONE: begin
          // ready follows the last apply cycle
          busy <= 1'b0;
          cfgReady <= 1'b1;
          if (reloadHit) begin
            cfgReady <= 1'b0;
            busy <= 1'b1;
            memAddr <= pcl_pkg::WORD_FIRST;
            wordsLoaded <= 4'h0;
            state <= pcl_pkg::PCL_ADDR;
          end
        end
        default: begin
          state <= pcl_pkg::PCL_IDLE;
          memReq <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // captured word, applied one cycle later
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      applyValid <= 1'b0;
      applyAddr <= 8'h00;
      applyData <= 16'h0000;
    end else if (ce) begin
      applyValid <= (state == pcl_pkg::PCL_WAIT) && memValid;
      if ((state == pcl_pkg::PCL_WAIT) && memValid) begin
        applyAddr <= memAddr;
        applyData <= memData;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-port field update
  // ----------------------------------------------------------------
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        cfgOff68[p] <= pcl_pkg::CFG_RESET;
        cfgOff74[p] <= pcl_pkg::CFG_RESET;
        cfgOff78[p] <= pcl_pkg::CFG_RESET;
        cfgOff7C[p] <= pcl_pkg::CFG_RESET;
        cfgOff84[p] <= pcl_pkg::CFG_RESET;
        cfgOff88[p] <= pcl_pkg::CFG_RESET;
        cfgOff8C[p] <= pcl_pkg::CFG_RESET;
        cfgOff90[p] <= pcl_pkg::CFG_RESET;
        cfgOff98[p] <= pcl_pkg::CFG_RESET;
      end else if (ce && applyValid) begin
        // only the mapped slices move; every other bit keeps its value
        case (applyAddr)
          pcl_pkg::WORD_DRIVE: begin
            cfgOff74[p][pcl_pkg::DST_NOMINAL_LSB +: pcl_pkg::SRC_TRIPLE_W] <=
              applyData[pcl_pkg::SRC_TRIPLE_LSB +: pcl_pkg::SRC_TRIPLE_W];
            cfgOff8C[p][pcl_pkg::DST_GEN2_BIT] <= applyData[pcl_pkg::SRC_TOP_BIT];
          end
          pcl_pkg::WORD_POST: begin
            cfgOff78[p][pcl_pkg::DST_NOMINAL_LSB +: pcl_pkg::SRC_TRIPLE_W] <=
              applyData[pcl_pkg::SRC_TRIPLE_LSB +: pcl_pkg::SRC_TRIPLE_W];
            cfgOff8C[p][pcl_pkg::DST_CTL6_BIT0] <= applyData[pcl_pkg::SRC_TOP_BIT];
          end
          pcl_pkg::WORD_LATENCY: begin
            cfgOff7C[p][pcl_pkg::DST_LAT_LSB +: pcl_pkg::SRC_LAT_W] <=
              applyData[pcl_pkg::SRC_TRIPLE_LSB +: pcl_pkg::SRC_LAT_W];
            cfgOff90[p][pcl_pkg::DST_HALFDELTA_LSB +: pcl_pkg::SRC_HALFDELTA_W] <=
              applyData[pcl_pkg::SRC_HALFDELTA_LSB +: pcl_pkg::SRC_HALFDELTA_W];
            cfgOff8C[p][pcl_pkg::DST_CTL6_MID_LSB +: pcl_pkg::SRC_NIBBLE_W] <=
              applyData[pcl_pkg::SRC_NIBBLE_HI_LSB +: pcl_pkg::SRC_NIBBLE_W];
          end
          pcl_pkg::WORD_CTL4_LO: begin
            cfgOff84[p][pcl_pkg::DST_LOW_HALF +: pcl_pkg::SRC_HALF_W] <= applyData;
          end
          pcl_pkg::WORD_CTL4_HI: begin
            cfgOff84[p][pcl_pkg::DST_HIGH_HALF +: pcl_pkg::SRC_HALF_W] <= applyData;
          end
          pcl_pkg::WORD_CTL5_LO: begin
            cfgOff88[p][pcl_pkg::DST_LOW_HALF +: pcl_pkg::SRC_HALF_W] <= applyData;
          end
          pcl_pkg::WORD_CTL5_HI: begin
            cfgOff88[p][pcl_pkg::DST_CTL5_HI_LSB +: pcl_pkg::SRC_BYTE_W] <=
              applyData[pcl_pkg::SRC_TRIPLE_LSB +: pcl_pkg::SRC_BYTE_W];
            cfgOff8C[p][pcl_pkg::DST_CTL6_HI_LSB +: pcl_pkg::SRC_CTL6_HI_W] <=
              applyData[pcl_pkg::SRC_CTL6_HI_LSB +: pcl_pkg::SRC_CTL6_HI_W];
            cfgOff98[p][pcl_pkg::DST_BUF_LSB +: pcl_pkg::SRC_BUF_W] <=
              applyData[pcl_pkg::SRC_BUF_LSB +: pcl_pkg::SRC_BUF_W];
          end
          pcl_pkg::WORD_DELTA: begin
            // six two-bit deltas sit back to back in both places
            cfgOff90[p][pcl_pkg::DST_DELTA_LSB +: pcl_pkg::SRC_DELTA_W] <=
              applyData[pcl_pkg::SRC_TRIPLE_LSB +: pcl_pkg::SRC_DELTA_W];
            cfgOff8C[p][pcl_pkg::DST_MAC_LSB +: pcl_pkg::SRC_NIBBLE_W] <=
              applyData[pcl_pkg::SRC_NIBBLE_HI_LSB +: pcl_pkg::SRC_NIBBLE_W];
          end
          pcl_pkg::WORD_PORT0: begin
            if (p == 0) begin
              cfgOff78[p][pcl_pkg::DST_FTS_LSB +: pcl_pkg::SRC_BYTE_W] <=
                applyData[pcl_pkg::SRC_TRIPLE_LSB +: pcl_pkg::SRC_BYTE_W];
              cfgOff68[p][pcl_pkg::DST_DESKEW_LSB +: pcl_pkg::SRC_DESKEW_W] <=
                applyData[pcl_pkg::SRC_DESKEW_LSB +: pcl_pkg::SRC_DESKEW_W];
              cfgOff78[p][pcl_pkg::DST_SCRAM_LSB +: pcl_pkg::SRC_SCRAM_W] <=
                applyData[pcl_pkg::SRC_SCRAM_LSB +: pcl_pkg::SRC_SCRAM_W];
              cfgOff78[p][pcl_pkg::DST_SPEED_LSB +: pcl_pkg::SRC_SPEED_W] <=
                applyData[pcl_pkg::SRC_SPEED_LSB +: pcl_pkg::SRC_SPEED_W];
            end
          end
          pcl_pkg::WORD_PORT1: begin
            // upper bits of this word belong to a later stage, not mapped here
            if (p == 1) begin
              cfgOff78[p][pcl_pkg::DST_FTS_LSB +: pcl_pkg::SRC_BYTE_W] <=
                applyData[pcl_pkg::SRC_TRIPLE_LSB +: pcl_pkg::SRC_BYTE_W];
              cfgOff68[p][pcl_pkg::DST_DESKEW_LSB +: pcl_pkg::SRC_DESKEW_W] <=
                applyData[pcl_pkg::SRC_DESKEW_LSB +: pcl_pkg::SRC_DESKEW_W];
            end
          end
          default: begin
            cfgOff68[p] <= cfgOff68[p];
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      autoLoad <= 1'b1;
    end else if (ce) begin
      // a software write wins over the self-clear so a set is never lost
      if (regWrite && regAddr == pcl_pkg::REG_CONTROL) begin
        autoLoad <= regWrData[pcl_pkg::CTL_AUTO_BIT];
      end else if (state == pcl_pkg::PCL_IDLE && autoLoad) begin
        autoLoad <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdData <= 32'h0000_0000;
    end else if (ce) begin
      regRdData <= 32'h0000_0000;
      if (regRead && regAddr == pcl_pkg::REG_STATUS) begin
        regRdData <= {24'h00_0000, wordsLoaded, 2'b00, cfgReady, busy};
      end
    end
  end

endmodule : pcl_loader

// [hdl/pcl_pkg.sv]
package pcl_pkg;
  // ----------------------------------------------------------------
  // load word addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] WORD_FIRST = 8'h10;
  localparam logic [7:0] WORD_LAST = 8'h22;
  localparam logic [7:0] WORD_STEP = 8'h02;
  localparam logic [7:0] WORD_DRIVE = 8'h10;
  localparam logic [7:0] WORD_POST = 8'h12;
  localparam logic [7:0] WORD_LATENCY = 8'h14;
  localparam logic [7:0] WORD_CTL4_LO = 8'h16;
  localparam logic [7:0] WORD_CTL4_HI = 8'h18;
  localparam logic [7:0] WORD_CTL5_LO = 8'h1A;
  localparam logic [7:0] WORD_CTL5_HI = 8'h1C;
  localparam logic [7:0] WORD_DELTA = 8'h1E;
  localparam logic [7:0] WORD_PORT0 = 8'h20;
  localparam logic [7:0] WORD_PORT1 = 8'h22;
  localparam int WORD_COUNT = 10;

  // ----------------------------------------------------------------
  // source slices inside a load word
  // ----------------------------------------------------------------
  localparam int SRC_TRIPLE_LSB = 0;
  localparam int SRC_TRIPLE_W = 15;
  localparam int SRC_TOP_BIT = 15;
  localparam int SRC_LAT_W = 7;
  localparam int SRC_HALFDELTA_LSB = 7;
  localparam int SRC_HALFDELTA_W = 5;
  localparam int SRC_NIBBLE_HI_LSB = 12;
  localparam int SRC_NIBBLE_W = 4;
  localparam int SRC_HALF_W = 16;
  localparam int SRC_BYTE_W = 8;
  localparam int SRC_CTL6_HI_LSB = 8;
  localparam int SRC_CTL6_HI_W = 3;
  localparam int SRC_BUF_LSB = 11;
  localparam int SRC_BUF_W = 5;
  localparam int SRC_DELTA_W = 12;
  localparam int SRC_DESKEW_LSB = 8;
  localparam int SRC_DESKEW_W = 2;
  localparam int SRC_SCRAM_LSB = 10;
  localparam int SRC_SCRAM_W = 3;
  localparam int SRC_SPEED_LSB = 13;
  localparam int SRC_SPEED_W = 3;

  // ----------------------------------------------------------------
  // destination fields in the per-port configuration words
  // ----------------------------------------------------------------
  localparam int DST_NOMINAL_LSB = 16;
  localparam int DST_GEN2_BIT = 31;
  localparam int DST_CTL6_BIT0 = 16;
  localparam int DST_LAT_LSB = 0;
  localparam int DST_HALFDELTA_LSB = 15;
  localparam int DST_CTL6_MID_LSB = 17;
  localparam int DST_LOW_HALF = 0;
  localparam int DST_HIGH_HALF = 16;
  localparam int DST_CTL5_HI_LSB = 16;
  localparam int DST_CTL6_HI_LSB = 21;
  localparam int DST_BUF_LSB = 16;
  localparam int DST_DELTA_LSB = 20;
  localparam int DST_MAC_LSB = 26;
  localparam int DST_FTS_LSB = 0;
  localparam int DST_DESKEW_LSB = 13;
  localparam int DST_SCRAM_LSB = 8;
  localparam int DST_SPEED_LSB = 12;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTL_RELOAD_BIT = 0;
  localparam int CTL_AUTO_BIT = 1;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    PCL_IDLE = 4'b0001,
    PCL_ADDR = 4'b0010,
    PCL_WAIT = 4'b0100,
    PCL_DONE = 4'b1000
  } pcl_state_t;
endpackage : pcl_pkg

// [sim/pcl_eeprom_model.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// word store answering fetches
// ----------------------------------------------------------------
module pcl_eeprom_model (
  input wire logic clk_sys,
  input wire logic memReq,
  input wire logic [7:0] memAddr,
  input wire logic [15:0] seed,
  input wire logic [3:0] delay,
  output logic memValid,
  output logic [15:0] memData
);
  logic [3:0] waitCnt = 4'h0;
  initial memValid = 1'b0;
  initial memData = 16'h0000;
  // data line toggles when idle so a stale word never passes
  always @(posedge clk_sys) begin
    memValid <= 1'b0;
    memData <= ~memData;
    if (memReq && !memValid) begin
      if (waitCnt >= delay) begin
        memValid <= 1'b1;
        memData <= {memAddr, memAddr} ^ seed;
        waitCnt <= 4'h0;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule : pcl_eeprom_model

// [sim/pcl_loader_assertions.sv]
`timescale 1ns/100ps
module pcl_loader_assertions #(
  parameter int PORTS = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic memReq,
  input wire logic [7:0] memAddr,
  input wire logic memValid,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic cfgReady,
  input wire logic [PORTS-1:0][31:0] cfgOff68,
  input wire logic [PORTS-1:0][31:0] cfgOff74,
  input wire logic [PORTS-1:0][31:0] cfgOff78,
  input wire logic [PORTS-1:0][31:0] cfgOff84,
  input wire logic [PORTS-1:0][31:0] cfgOff8C
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_ADDR_HOLD: assert property (ce && memReq && !memValid |=> memReq && $stable(memAddr))
    else $error("fetch dropped or address moved");
  AST_REQ_END: assert property (ce && memReq && memValid |=> !memReq)
    else $error("fetch request held after word");
  AST_ADDR_NEXT: assert property (ce && memReq && memValid && memAddr != 8'h22 |=> memAddr == $past(memAddr) + 8'h02)
    else $error("fetch order broken");
  AST_ADDR_LEGAL: assert property (memReq |-> memAddr inside {[8'h10:8'h22]} && !memAddr[0])
    else $error("fetch address out of range");
  AST_RD_IDLE: assert property (!$past(regRead) |-> regRdData == 32'h0000_0000)
    else $error("read data without read");
  AST_RD_UNMAPPED: assert property (regRead && regAddr != pcl_pkg::REG_STATUS |=> regRdData == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_RD_READY: assert property (regRead && regAddr == pcl_pkg::REG_STATUS |=> regRdData[1] == $past(cfgReady))
    else $error("status ready bit wrong");
  AST_BROADCAST: assert property (cfgReady |-> cfgOff74[PORTS-1] == cfgOff74[0] && cfgOff84[PORTS-1] == cfgOff84[0]
      && cfgOff8C[PORTS-1] == cfgOff8C[0])
    else $error("broadcast fields differ");
  AST_PORT_ONLY: assert property (cfgOff68[PORTS-1] == 32'h0000_0000 && cfgOff78[PORTS-1][15:0] == 16'h0000)
    else $error("unloaded port field changed");
endmodule : pcl_loader_assertions

bind pcl_loader pcl_loader_assertions #(.PORTS(PORTS)) i_pcl_loader_assertions (.clk_sys(clk_sys),
  .reset_n(reset_n), .ce(ce), .memReq(memReq), .memAddr(memAddr), .memValid(memValid), .regAddr(regAddr),
  .regRead(regRead), .regRdData(regRdData), .cfgReady(cfgReady), .cfgOff68(cfgOff68), .cfgOff74(cfgOff74),
  .cfgOff78(cfgOff78), .cfgOff84(cfgOff84), .cfgOff8C(cfgOff8C));

// [sim/pcl_loader_tb_top.sv]
`timescale 1ns/100ps
module pcl_loader_tb_top;
  localparam int PORTS = 4;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic memReq, memValid, cfgReady;
  logic [7:0] memAddr;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] memData;
  logic [15:0] seed = 16'h3C5A;
  logic [3:0] delay = 4'h0;
  logic [31:0] regWrData = 32'h0000_0000;
  logic [31:0] regRdData, got;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic ce = 1'b1;
  logic [PORTS-1:0][31:0] cfgOff68, cfgOff74, cfgOff78, cfgOff7C, cfgOff84, cfgOff88, cfgOff8C, cfgOff90, cfgOff98;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // design and word store
  // ----------------------------------------------------------------
  pcl_loader #(.PORTS(PORTS)) i_pcl_loader (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .memReq(memReq),
    .memAddr(memAddr), .memValid(memValid), .memData(memData), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .cfgReady(cfgReady), .cfgOff68(cfgOff68),
    .cfgOff74(cfgOff74), .cfgOff78(cfgOff78), .cfgOff7C(cfgOff7C), .cfgOff84(cfgOff84), .cfgOff88(cfgOff88),
    .cfgOff8C(cfgOff8C), .cfgOff90(cfgOff90), .cfgOff98(cfgOff98));
  pcl_eeprom_model i_pcl_eeprom_model (.clk_sys(clk_sys), .memReq(memReq), .memAddr(memAddr), .seed(seed),
    .delay(delay), .memValid(memValid), .memData(memData));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask : chk

  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : regWr

  // read data stands only in the cycle after the strobe edge
  task automatic regRd(input logic [7:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 got = regRdData;
  endtask : regRd

  task automatic waitReady();
    for (int n = 0; n < 3000 && cfgReady !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({31'h0000_0000, cfgReady}, 32'h0000_0001);
  endtask : waitReady

  task automatic checkAll();
    logic [15:0] v [0:9];
    for (int i = 0; i < 10; i++) v[i] = {8'h10 + 8'(2 * i), 8'h10 + 8'(2 * i)} ^ seed;
    for (int p = 0; p < PORTS; p++) begin
      chk(cfgOff74[p], {1'b0, v[0][14:0], 16'h0000});
      chk(cfgOff78[p], {1'b0, v[1][14:0], 16'h0000} | ((p == 0) ? {17'h0_0000, v[8][15:13], 1'b0, v[8][12:10],
        v[8][7:0]} : (p == 1) ? {24'h00_0000, v[9][7:0]} : 32'h0000_0000));
      chk(cfgOff68[p], (p == 0) ? {17'h0_0000, v[8][9:8], 13'h0000} : (p == 1) ? {17'h0_0000, v[9][9:8],
        13'h0000} : 32'h0000_0000);
      chk(cfgOff7C[p], {25'h000_0000, v[2][6:0]});
      chk(cfgOff84[p], {v[4], v[3]});
      chk(cfgOff88[p], {8'h00, v[6][7:0], v[5]});
      chk(cfgOff8C[p], {v[0][15], 1'b0, v[7][15:12], 2'b00, v[6][10:8], v[2][15:12], v[1][15], 16'h0000});
      chk(cfgOff90[p], {v[7][11:0], v[2][11:7], 15'h0000});
      chk(cfgOff98[p], {11'h000, v[6][15:11], 16'h0000});
    end
  endtask : checkAll

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    chk(cfgOff74[0], 32'h0000_0000);
    reset_n <= 1'b1;
    waitReady();
    checkAll();
    regRd(pcl_pkg::REG_STATUS);
    chk(got, 32'h0000_00A2);
    regRd(8'h40);
    chk(got, 32'h0000_0000);
    // slow store and fresh contents prove the reload overwrites
    @(posedge clk_sys);
    seed <= 16'hC3A5;
    delay <= 4'h5;
    regWr(pcl_pkg::REG_CONTROL, 32'h0000_0001);
    regRd(pcl_pkg::REG_STATUS);
    chk({30'h0000_0000, got[1:0]}, 32'h0000_0001);
    regRd(pcl_pkg::REG_CONTROL);
    chk(got, 32'h0000_0000);
    waitReady();
    checkAll();
    regRd(pcl_pkg::REG_STATUS);
    chk(got, 32'h0000_00A2);
    // a reload written while the enable is low must be ignored
    @(posedge clk_sys);
    ce <= 1'b0;
    regWr(pcl_pkg::REG_CONTROL, 32'h0000_0001);
    @(posedge clk_sys);
    ce <= 1'b1;
    regRd(pcl_pkg::REG_STATUS);
    chk(got, 32'h0000_00A2);
    checkAll();
    conclude();
  end
endmodule : pcl_loader_tb_top
